// ==== uart_line_ctrl.sv ====
// Purpose: serial port with FIFO control, character format and line status over AHB-Lite
// Assumes: single word transfers, rxd asynchronous to hclk, 16x oversampling from divisor
// Notes: reads take one wait state, writes none; response always OKAY
// How it works
// - fifo_control bit 0 enables both FIFOs and unlocks writes to bits 7:1.
// - any change of the FIFO enable bit empties both FIFOs.
// - writing one to fifo_control bit 1 empties the receive FIFO; bit self-clears.
// - writing one to fifo_control bit 2 empties the transmit FIFO; bit self-clears.
// - fifo_control bits 7:6 pick receive trigger of 1, 4, 8 or 14 characters.
// - line_control bits 1:0 pick 5, 6, 7 or 8 data bits both ways.
// - line_control bit 2 gives two stop bits, one and a half with 5 bits.
// - line_control bit 3 turns parity generation and checking on.
// - line_control bits 5:4 pick odd, even, forced one or forced zero parity.
// - line_control bit 6 holds the transmit line low to send a break.
// - line_control bit 7 swaps the data word for the baud divisor latch.
// - line_status bit 0 reads one while the receive FIFO holds a character.
// - character finishing into a full receive FIFO sets overrun and is dropped.
// - reading line_status clears the overrun flag.
// - wrong received parity sets line_status bit 2; reading line_status clears it.
// - parity error belongs to the FIFO head character; timing depends on FIFO enable.
// - line_status is read-only; writes do nothing.
// - receive fill interrupt is high while fill is at or above trigger; with FIFOs off, while one character is held.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "uart_lc_regs.svh"

module uart_line_ctrl #(
    parameter int DEPTH = 16
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // asynchronous reset, low active
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always OKAY
    output logic [31:0] hrdata, // read data
    input wire logic rxd, // serial input
    output logic txd, // serial output
    output logic irq // level interrupt
);
    import uart_lc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 14 || (DEPTH & (DEPTH - 1)) != 0) begin : bad_depth
            $error("DEPTH must be a power of two of at least 14");
        end
    endgenerate

    // bus front end
    logic wr_pend;
    logic rd_pend;
    logic [31:0] a_addr;
    logic take;
    assign take = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            a_addr <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= take & hwrite;
            rd_pend <= take & ~hwrite;
            if (take) begin
                a_addr <= haddr;
            end
            hreadyout <= ~(take & ~hwrite);
            hresp <= 1'b0;
        end
    end

    // registers
    logic fifo_en;
    logic [1:0] trig;
    logic [7:0] line_control;
    logic [15:0] divisor;
    logic [2:0] imask;
    logic [2:0] ist;
    logic oe_flag;
    logic parity_error_flag;
    logic dlab;
    assign dlab = line_control[`LCR_DLAB_BIT];

    logic wr_fcr, wr_lcr, wr_data, wr_div, wr_imask;
    logic rd_lsr, rd_data, rd_ist;
    assign wr_fcr = wr_pend && a_addr == `FCR_ADDR;
    assign wr_lcr = wr_pend && a_addr == `LCR_ADDR;
    assign wr_data = wr_pend && a_addr == `DATA_ADDR && !dlab;
    assign wr_div = wr_pend && a_addr == `DATA_ADDR && dlab;
    assign wr_imask = wr_pend && a_addr == `IMASK_ADDR;
    assign rd_lsr = rd_pend && a_addr == `LSR_ADDR;
    assign rd_data = rd_pend && a_addr == `DATA_ADDR && !dlab;
    assign rd_ist = rd_pend && a_addr == `IST_ADDR;

    logic en_toggle;
    logic flush_rx, flush_tx;
    assign en_toggle = wr_fcr && (hwdata[`FCR_EN_BIT] != fifo_en);
    assign flush_rx = en_toggle || (wr_fcr && hwdata[`FCR_EN_BIT] && hwdata[`FCR_RXRST_BIT]);
    assign flush_tx = en_toggle || (wr_fcr && hwdata[`FCR_EN_BIT] && hwdata[`FCR_TXRST_BIT]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_en <= 1'b0;
            trig <= `TRIG_RESET;
        end else if (wr_fcr) begin
            fifo_en <= hwdata[`FCR_EN_BIT];
            if (hwdata[`FCR_EN_BIT]) begin
                trig <= hwdata[`FCR_TRIG_HI:`FCR_TRIG_LO];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_control <= `LCR_RESET;
            divisor <= `DIV_RESET;
            imask <= `IMASK_RESET;
        end else begin
            if (wr_lcr) begin
                line_control <= hwdata[7:0];
            end
            if (wr_div) begin
                divisor <= hwdata[15:0];
            end
            if (wr_imask) begin
                imask <= hwdata[2:0];
            end
        end
    end

    // character format
    logic [3:0] nbits;
    parity_type psel;
    logic pen;
    assign nbits = `MIN_WORD_BITS + {2'b00, line_control[`LCR_WLS_HI:`LCR_WLS_LO]};
    assign psel = parity_type'(line_control[`LCR_PSEL_HI:`LCR_PSEL_LO]);
    assign pen = line_control[`LCR_PEN_BIT];

    function automatic logic par_bit(input logic [7:0] d, input parity_type p);
        case (p)
            PAR_ODD: par_bit = ~^d;
            PAR_EVEN: par_bit = ^d;
            PAR_ONE: par_bit = 1'b1;
            PAR_ZERO: par_bit = 1'b0;
            default: par_bit = 1'b0;
        endcase
    endfunction : par_bit

    // one character deep when the FIFOs are off
    logic [AW:0] lim;
    assign lim = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);

    // receive FIFO, parity error kept beside each character
    logic [8:0] rx_mem [DEPTH];
    logic [AW-1:0] rx_wp, rx_rp;
    logic [AW:0] rx_cnt;
    logic rx_done;
    logic [7:0] rx_char;
    logic rx_perr;
    logic rx_push, rx_pop, overrun;
    assign rx_push = rx_done && rx_cnt < lim && !flush_rx;
    assign overrun = rx_done && !(rx_cnt < lim);
    assign rx_pop = rd_data && rx_cnt != '0;

    always_ff @(posedge hclk) begin
        if (rx_push) begin
            rx_mem[rx_wp] <= {rx_perr, rx_char};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
        end else if (flush_rx) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
        end else begin
            if (rx_push) begin
                rx_wp <= rx_wp + 1'b1;
            end
            if (rx_pop) begin
                rx_rp <= rx_rp + 1'b1;
            end
            rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        end
    end

    // transmit FIFO
    logic [7:0] tx_mem [DEPTH];
    logic [AW-1:0] tx_wp, tx_rp;
    logic [AW:0] tx_cnt;
    logic tx_push, tx_pop;
    assign tx_push = wr_data && tx_cnt < lim && !flush_tx;

    always_ff @(posedge hclk) begin
        if (tx_push) begin
            tx_mem[tx_wp] <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
        end else if (flush_tx) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_wp + 1'b1;
            end
            if (tx_pop) begin
                tx_rp <= tx_rp + 1'b1;
            end
            tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        end
    end

    // line status flags; set wins over the read clear
    logic head_fresh;
    logic pe_set;
    assign pe_set = fifo_en ? (head_fresh && rx_cnt != '0 && rx_mem[rx_rp][8])
                            : (rx_push && rx_perr);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head_fresh <= 1'b0;
            oe_flag <= 1'b0;
            parity_error_flag <= 1'b0;
        end else begin
            head_fresh <= !flush_rx && ((rx_push && rx_cnt == '0)
                          || (rx_pop && (rx_cnt > (AW+1)'(1) || rx_push)));
            if (overrun) begin
                oe_flag <= 1'b1;
            end else if (rd_lsr) begin
                oe_flag <= 1'b0;
            end
            if (pe_set) begin
                parity_error_flag <= 1'b1;
            end else if (rd_lsr) begin
                parity_error_flag <= 1'b0;
            end
        end
    end

    // receive fill interrupt and event status
    logic [4:0] trig_count;
    logic rx_fill_interrupt;
    always_comb begin
        case (trig)
            2'h0: trig_count = `TRIG_LVL0;
            2'h1: trig_count = `TRIG_LVL1;
            2'h2: trig_count = `TRIG_LVL2;
            default: trig_count = `TRIG_LVL3;
        endcase
    end

    logic [2:0] ist_set;
    assign ist_set = {tx_pop && tx_cnt == (AW+1)'(1),
                      overrun || pe_set,
                      rx_fill_interrupt};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_fill_interrupt <= 1'b0;
            ist <= 3'h0;
            irq <= 1'b0;
        end else begin
            rx_fill_interrupt <= fifo_en ? (rx_cnt >= (AW+1)'(trig_count))
                                         : (rx_cnt != '0);
            ist <= ist_set | (rd_ist ? 3'h0 : ist);
            irq <= |(ist & imask);
        end
    end

    // read data, one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend) begin
            case (a_addr)
                `DATA_ADDR: hrdata <= dlab ? {16'h0000, divisor}
                                           : {24'h000000, rx_cnt != '0 ? rx_mem[rx_rp][7:0] : 8'h00};
                `FCR_ADDR: hrdata <= {24'h000000, trig, 5'h00, fifo_en};
                `LCR_ADDR: hrdata <= {24'h000000, line_control};
                `LSR_ADDR: hrdata <= {29'h00000000, parity_error_flag, oe_flag,
                                      rx_cnt != '0};
                `IST_ADDR: hrdata <= {29'h00000000, ist};
                `IMASK_ADDR: hrdata <= {29'h00000000, imask};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // 16x baud tick
    logic [15:0] div_cnt;
    logic tick;
    assign tick = div_cnt == 16'h0000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= tick ? divisor - 16'h0001 : div_cnt - 16'h0001;
        end
    end

    // transmitter
    line_state_type tx_state;
    logic [5:0] tx_sub;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic tx_line;
    logic [5:0] tx_len;
    always_comb begin
        tx_len = `OVERSAMPLE;
        if (tx_state == LINE_STOP && line_control[`LCR_STOP_BIT]) begin
            tx_len = (nbits == `MIN_WORD_BITS) ? `OVERSAMPLE + `MID_SAMPLE
                                               : `OVERSAMPLE + `OVERSAMPLE;
        end
    end
    assign tx_pop = tx_state == LINE_IDLE && tx_cnt != '0 && !flush_tx;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state <= LINE_IDLE;
            tx_sub <= 6'h00;
            tx_idx <= 3'h0;
            tx_shift <= 8'h00;
            tx_line <= 1'b1;
        end else if (tx_pop) begin
            tx_state <= LINE_START;
            tx_sub <= 6'h00;
            tx_shift <= tx_mem[tx_rp] & ~(8'hFF << nbits);
            tx_line <= 1'b0;
        end else if (tick && tx_state != LINE_IDLE) begin
            tx_sub <= tx_sub + 6'h01;
            if (tx_sub == tx_len - 6'h01) begin
                tx_sub <= 6'h00;
                case (tx_state)
                    LINE_START: begin
                        tx_state <= LINE_DATA;
                        tx_idx <= 3'h0;
                        tx_line <= tx_shift[0];
                    end
                    LINE_DATA: begin
                        if (4'(tx_idx) == nbits - 4'h1) begin
                            tx_state <= pen ? LINE_PARITY : LINE_STOP;
                            tx_line <= pen ? par_bit(tx_shift, psel) : 1'b1;
                        end else begin
                            tx_idx <= tx_idx + 3'h1;
                            tx_line <= tx_shift[tx_idx + 3'h1];
                        end
                    end
                    LINE_PARITY: begin
                        tx_state <= LINE_STOP;
                        tx_line <= 1'b1;
                    end
                    default: tx_state <= LINE_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txd <= 1'b1;
        end else begin
            txd <= tx_line & ~line_control[`LCR_BREAK_BIT];
        end
    end

    // receiver
    logic rx_s1, rx_s2;
    line_state_type rx_state;
    logic [5:0] rx_sub;
    logic [3:0] rx_idx;
    logic [7:0] rx_shift;
    logic [7:0] rx_word;
    logic rx_pbit;
    assign rx_word = 8'(rx_shift >> (4'h8 - nbits));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= rxd;
            rx_s2 <= rx_s1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state <= LINE_IDLE;
            rx_sub <= 6'h00;
            rx_idx <= 4'h0;
            rx_shift <= 8'h00;
            rx_pbit <= 1'b0;
            rx_done <= 1'b0;
            rx_char <= 8'h00;
            rx_perr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            case (rx_state)
                LINE_IDLE: begin
                    rx_sub <= 6'h00;
                    if (!rx_s2) begin
                        rx_state <= LINE_START;
                    end
                end
                LINE_START: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 6'h01;
                        if (rx_sub == `MID_SAMPLE - 6'h01) begin
                            rx_sub <= 6'h00;
                            rx_idx <= 4'h0;
                            rx_state <= rx_s2 ? LINE_IDLE : LINE_DATA;
                        end
                    end
                end
                LINE_DATA, LINE_PARITY, LINE_STOP: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 6'h01;
                        if (rx_sub == `OVERSAMPLE - 6'h01) begin
                            rx_sub <= 6'h00;
                            if (rx_state == LINE_DATA) begin
                                rx_shift <= {rx_s2, rx_shift[7:1]};
                                rx_idx <= rx_idx + 4'h1;
                                if (rx_idx == nbits - 4'h1) begin
                                    rx_state <= pen ? LINE_PARITY : LINE_STOP;
                                end
                            end else if (rx_state == LINE_PARITY) begin
                                rx_pbit <= rx_s2;
                                rx_state <= LINE_STOP;
                            end else begin
                                rx_done <= 1'b1;
                                rx_char <= rx_word;
                                rx_perr <= pen && (rx_pbit != par_bit(rx_word, psel));
                                rx_state <= LINE_IDLE;
                            end
                        end
                    end
                end
                default: rx_state <= LINE_IDLE;
            endcase
        end
    end

endmodule : uart_line_ctrl

// ==== uart_lc_regs.svh ====
// Purpose: register map, field positions, reset values and timing counts of the serial port
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one register to an aligned word
// Notes: definitions only
`ifndef UART_LC_REGS_SVH
`define UART_LC_REGS_SVH

`define DATA_ADDR 32'hE000C000
`define FCR_ADDR 32'hE000C008
`define LCR_ADDR 32'hE000C00C
`define LSR_ADDR 32'hE000C014
`define IST_ADDR 32'hE000C020
`define IMASK_ADDR 32'hE000C024

`define FCR_EN_BIT 0
`define FCR_RXRST_BIT 1
`define FCR_TXRST_BIT 2
`define FCR_TRIG_HI 7
`define FCR_TRIG_LO 6

`define LCR_WLS_HI 1
`define LCR_WLS_LO 0
`define LCR_STOP_BIT 2
`define LCR_PEN_BIT 3
`define LCR_PSEL_HI 5
`define LCR_PSEL_LO 4
`define LCR_BREAK_BIT 6
`define LCR_DLAB_BIT 7

`define LSR_RDR_BIT 0
`define LSR_OE_BIT 1
`define LSR_PE_BIT 2

`define IST_RXFILL_BIT 0
`define IST_LINEERR_BIT 1
`define IST_TXEMPTY_BIT 2

`define LCR_RESET 8'h00
`define TRIG_RESET 2'h0
`define IMASK_RESET 3'h0
`define DIV_RESET 16'h0001

`define TRIG_LVL0 5'h01
`define TRIG_LVL1 5'h04
`define TRIG_LVL2 5'h08
`define TRIG_LVL3 5'h0E

`define MIN_WORD_BITS 4'h5
`define OVERSAMPLE 6'h10
`define MID_SAMPLE 6'h08

`endif

// ==== uart_lc_pkg.sv ====
// Purpose: shared types of the serial port
// Assumes: nothing beyond the register header
// Notes: states carry no explicit codes
package uart_lc_pkg;

    typedef enum logic [2:0] {
        LINE_IDLE,
        LINE_START,
        LINE_DATA,
        LINE_PARITY,
        LINE_STOP
    } line_state_type;

    typedef enum logic [1:0] {
        PAR_ODD,
        PAR_EVEN,
        PAR_ONE,
        PAR_ZERO
    } parity_type;

endpackage : uart_lc_pkg

// ==== uart_line_ctrl_chk.sv ====
// Purpose: port-level checks of the serial port
// Assumes: hready is tied to hreadyout
// Notes: bound to uart_line_ctrl at the foot
`timescale 1ns/10ps
`include "uart_lc_regs.svh"
module uart_line_ctrl_chk (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, low active
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // read data
    input wire logic txd // serial output
);
    logic take, mapped, lcr_wr, fcr_wr;
    logic [7:0] lcr_m, fcr_m;
    assign take = hsel && htrans[1] && hready;
    assign mapped = haddr inside {`DATA_ADDR, `FCR_ADDR, `LCR_ADDR, `LSR_ADDR, `IST_ADDR,
        `IMASK_ADDR};
    // mirrors of the two control registers, updated at the data phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lcr_wr <= 1'b0;
            fcr_wr <= 1'b0;
            lcr_m <= `LCR_RESET;
            fcr_m <= 8'h00;
        end else begin
            lcr_wr <= take && hwrite && haddr == `LCR_ADDR;
            fcr_wr <= take && hwrite && haddr == `FCR_ADDR;
            if (lcr_wr) begin
                lcr_m <= hwdata[7:0];
            end
            if (fcr_wr) begin
                fcr_m <= hwdata[0] ? {hwdata[7:6], 6'h01} : {fcr_m[7:6], 6'h00};
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_at(logic [31:0] a);
        take && !hwrite && haddr == a;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    lcr_readback_a: assert property (rd_at(`LCR_ADDR) |-> ##2 hrdata == {24'h0, lcr_m})
        else $error("line control read mismatch");
    fcr_readback_a: assert property (rd_at(`FCR_ADDR) |-> ##2 hrdata == {24'h0, fcr_m})
        else $error("fifo control read mismatch");
    break_low_a: assert property (lcr_m[6] && $past(lcr_m[6]) |-> !txd)
        else $error("txd not low in break");
    lsr_upper_a: assert property (rd_at(`LSR_ADDR) |-> ##2 hrdata[31:3] == 29'h0)
        else $error("line status upper bits set");
    unmapped_zero_a: assert property (take && !hwrite && !mapped |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    read_wait_a: assert property (take && !hwrite |=> one_wait)
        else $error("read wait not one cycle");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
        else $error("hrdata changed outside read");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not OKAY");
endmodule : uart_line_ctrl_chk
bind uart_line_ctrl uart_line_ctrl_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd(txd));

// ==== uart_peer.sv ====
// Purpose: remote serial peer on rxd and txd
// Assumes: divisor 1, so 16 hclk cycles a bit
// Notes: tasks are called from the bench
`timescale 1ns/10ps
module uart_peer (
    input wire logic hclk, // clock
    input wire logic txd, // port output
    output logic rxd // port input
);
    initial rxd = 1'b1;
    task automatic bit_out(input logic b);
        rxd <= b;
        repeat (16) @(posedge hclk);
    endtask : bit_out
    // 8 data bits, lsb first, optional parity, one stop
    task automatic send(input logic [7:0] d, input logic pen, input logic pb);
        int k;
        @(posedge hclk);
        bit_out(1'b0);
        for (k = 0; k < 8; k++) bit_out(d[k]);
        if (pen) bit_out(pb);
        bit_out(1'b1);
    endtask : send
    task automatic take(input int n, input logic pen, output logic [7:0] d,
        output logic pb, output int ts);
        int k;
        d = 8'h00;
        pb = 1'b0;
        @(negedge txd);
        // clock count from absolute time, free of edge ordering races
        ts = int'($time / 10);
        repeat (8) @(posedge hclk);
        for (k = 0; k < n + pen; k++) begin
            repeat (16) @(posedge hclk);
            if (k < n) d[k] = txd;
            else pb = txd;
        end
    endtask : take
endmodule : uart_peer

// ==== tb_uart_fifo_line_control_status.sv ====
// Purpose: self-checking bench of the serial port
// Assumes: divisor left at 1, 16 cycles a bit
// Notes: peer model drives rxd and decodes txd
`timescale 1ns/10ps
`include "uart_lc_regs.svh"
module tb_uart_fifo_line_control_status;
    logic hclk, hresetn, hsel, hwrite, txd, irq, rxd, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_fail, total_checks;
    uart_line_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd), .irq(irq));
    uart_peer peer (.hclk(hclk), .txd(txd), .rxd(rxd));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic finish_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        cmp(q, e);
    endtask : chk
    function automatic logic par(input logic [7:0] d, input logic [1:0] s);
        case (s)
            2'h0: par = ~^d;
            2'h1: par = ^d;
            default: par = ~s[0];
        endcase
    endfunction : par
    task automatic t_regs();
        chk(`LCR_ADDR, 32'h0);
        chk(`FCR_ADDR, 32'h0);
        chk(`LSR_ADDR, 32'h0);
        chk(32'hE000C018, 32'h0);
        wr(`LSR_ADDR, 32'hFF);
        chk(`LSR_ADDR, 32'h0);
        wr(`LCR_ADDR, 32'hBF);
        chk(`LCR_ADDR, 32'hBF);
        chk(`DATA_ADDR, 32'h1);
        wr(`LCR_ADDR, 32'h03);
        wr(`FCR_ADDR, 32'h41);
        chk(`FCR_ADDR, 32'h41);
        wr(`FCR_ADDR, 32'h80);
        chk(`FCR_ADDR, 32'h40);
        wr(`FCR_ADDR, 32'hC7);
        chk(`FCR_ADDR, 32'hC1);
    endtask : t_regs
    task automatic t_tx();
        logic [7:0] cfgs [5] = '{8'h0C, 8'h19, 8'h2E, 8'h3B, 8'h03};
        logic [7:0] d, m;
        logic p;
        int n, t0, t1, sp;
        foreach (cfgs[i]) begin
            n = cfgs[i][1:0] + 5;
            m = 8'hFF >> (8 - n);
            sp = 16 * (1 + n + cfgs[i][3]) + (cfgs[i][2] ? (n == 5 ? 24 : 32) : 16);
            wr(`LCR_ADDR, {24'h0, cfgs[i]});
            fork
                peer.take(n, cfgs[i][3], d, p, t0);
                begin
                    wr(`DATA_ADDR, 32'hA7);
                    wr(`DATA_ADDR, 32'h3C);
                end
            join
            cmp(d, 8'hA7 & m);
            if (cfgs[i][3]) cmp(p, par(8'hA7 & m, cfgs[i][5:4]));
            peer.take(n, cfgs[i][3], d, p, t1);
            cmp(d, 8'h3C & m);
            // one idle clock between characters
            cmp(32'(t1 - t0), 32'(sp + 1));
        end
        // let the last frame end so the line idles high
        repeat (40) @(posedge hclk);
        wr(`LCR_ADDR, 32'h43);
        repeat (3) @(posedge hclk);
        cmp(txd, 1'b0);
        wr(`LCR_ADDR, 32'h03);
        repeat (3) @(posedge hclk);
        cmp(txd, 1'b1);
    endtask : t_tx
    task automatic t_rx();
        wr(`LCR_ADDR, 32'h1B);
        peer.send(8'h5A, 1'b1, 1'b1);
        chk(`LSR_ADDR, 32'h05);
        chk(`LSR_ADDR, 32'h01);
        chk(`DATA_ADDR, 32'h5A);
        chk(`LSR_ADDR, 32'h00);
        peer.send(8'hA5, 1'b1, 1'b0);
        chk(`LSR_ADDR, 32'h01);
        chk(`DATA_ADDR, 32'hA5);
    endtask : t_rx
    task automatic t_ovr();
        wr(`LCR_ADDR, 32'h03);
        wr(`IMASK_ADDR, 32'h1);
        for (int i = 0; i < 17; i++) begin
            peer.send(8'(i), 1'b0, 1'b0);
            if (i == 12 || i == 13) cmp(irq, i == 13);
        end
        chk(`LSR_ADDR, 32'h03);
        chk(`LSR_ADDR, 32'h01);
        chk(`DATA_ADDR, 32'h00);
        wr(`IMASK_ADDR, 32'h0);
        repeat (2) @(posedge hclk);
        cmp(irq, 1'b0);
        wr(`IMASK_ADDR, 32'h1);
        repeat (2) @(posedge hclk);
        cmp(irq, 1'b1);
        wr(`FCR_ADDR, 32'hC3);
        chk(`LSR_ADDR, 32'h00);
        chk(`IST_ADDR, 32'h7);
        repeat (2) @(posedge hclk);
        cmp(irq, 1'b0);
        peer.send(8'h11, 1'b0, 1'b0);
        chk(`LSR_ADDR, 32'h01);
        wr(`FCR_ADDR, 32'h00);
        chk(`LSR_ADDR, 32'h00);
    endtask : t_ovr
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        finish_test();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        n_fail = 0;
        total_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_tx();
        t_rx();
        t_ovr();
        finish_test();
    end
endmodule : tb_uart_fifo_line_control_status
